//--- pst_params.svh
// Constants of the port statistics counter bank: locations, field layout, bins, message layout
`ifndef PST_PARAMS_SVH
`define PST_PARAMS_SVH

// ----------------------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------------------
`define PST_NUM_PORTS       10
`define PST_NUM_LOCS        16
`define PST_NUM_FLAGS       30
`define PST_WORD_W          32
`define PST_LEN_W           16
`define PST_NOTE_W          64
`define PST_NOTE_PORT_LO    30
`define PST_RESET_WORD      32'h0000_0000

// ----------------------------------------------------------------------------
// Counter locations in the per-port counter memory
// ----------------------------------------------------------------------------
`define PST_LOC_TX_BYTES    4'h0
`define PST_LOC_TX_UNI      4'h1
`define PST_LOC_TX_FC       4'h2
`define PST_LOC_RX_BYTES    4'h3
`define PST_LOC_RX_FRAMES   4'h4
`define PST_LOC_RX_TOTBYTES 4'h5
`define PST_LOC_RX_TOTFRM   4'h6
`define PST_LOC_RX_MCBC     4'h7
`define PST_LOC_BIN64       4'h8
`define PST_LOC_BIN65       4'h9
`define PST_LOC_BIN128      4'hA
`define PST_LOC_BIN512      4'hB
`define PST_LOC_ERR_C       4'hC
`define PST_LOC_ERR_D       4'hD
`define PST_LOC_COLL        4'hE
`define PST_LOC_DISC        4'hF

// ----------------------------------------------------------------------------
// Field kinds: low bit position and width
// ----------------------------------------------------------------------------
`define PST_LO_D            5'h00
`define PST_W_D             6'h20
`define PST_LO_L            5'h00
`define PST_W_L             6'h18
`define PST_LO_U            5'h18
`define PST_W_U             6'h08
`define PST_LO_U1           5'h10
`define PST_W_U1            6'h08
`define PST_LO_LL           5'h00
`define PST_W_LL            6'h10
`define PST_LO_UU           5'h10
`define PST_W_UU            6'h10
`define PST_FK_D            {`PST_LO_D, `PST_W_D}
`define PST_FK_L            {`PST_LO_L, `PST_W_L}
`define PST_FK_U            {`PST_LO_U, `PST_W_U}
`define PST_FK_U1           {`PST_LO_U1, `PST_W_U1}
`define PST_FK_LL           {`PST_LO_LL, `PST_W_LL}
`define PST_FK_UU           {`PST_LO_UU, `PST_W_UU}

// ----------------------------------------------------------------------------
// Wrap flag indices fed by dedicated sources
// ----------------------------------------------------------------------------
`define PST_F_TX_BYTES      0
`define PST_F_SEND_FAIL     2
`define PST_F_RX_BYTES      5
`define PST_F_RX_TOTBYTES   7
`define PST_F_BIN64         12
`define PST_F_BIN65         14
`define PST_F_BIN128        16
`define PST_F_BIN256        17
`define PST_F_BIN512        18
`define PST_F_BIN1024       19
`define PST_F_FILTER        27
`define PST_F_DELAY         28

// ----------------------------------------------------------------------------
// Frame length bins (inclusive upper bounds)
// ----------------------------------------------------------------------------
`define PST_LEN_64          16'h0040
`define PST_LEN_127         16'h007F
`define PST_LEN_255         16'h00FF
`define PST_LEN_511         16'h01FF
`define PST_LEN_1023        16'h03FF
`define PST_LEN_1528        16'h05F8

`endif

//--- pst_pkg.sv
// Types of the port statistics counter bank
package pst_pkg;
  typedef logic [31:0] pst_word_t;
  typedef enum logic {PST_NOTE_IDLE, PST_NOTE_OFFER} pst_note_state_t;
endpackage : pst_pkg

//--- pst_counter_bank.sv
// One port's counter memory with field-wise wrapping increments
`timescale 1ns/1ps
`include "pst_params.svh"

module pst_counter_bank
  import pst_pkg::*;
#(
  parameter int LEN_W = `PST_LEN_W
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // MAC events, one pulse per flag position
  input  wire logic [29:0]              macEvent,
  input  wire logic                     sendFailUnderrun,
  input  wire logic                     sendFailLateCol,
  input  wire logic                     sendFailSixteenCol,
  input  wire logic                     frameDone,
  input  wire logic [LEN_W-1:0]         frameLen,
  input  wire logic [LEN_W-1:0]         txByteCount,
  input  wire logic [LEN_W-1:0]         rxByteCount,
  input  wire logic [LEN_W-1:0]         rxTotByteCount,
  // Queue and buffer manager events
  input  wire logic                     filterDiscard,
  input  wire logic                     delayDiscard,
  // Counter words and wrap pulses
  output logic [16*32-1:0]              memFlat,
  output logic [29:0]                   wrap
);

  pst_word_t   mem     [`PST_NUM_LOCS];
  pst_word_t   next_mem[`PST_NUM_LOCS];
  logic [29:0] inc;
  logic [32:0] amount  [`PST_NUM_FLAGS];

  // ----------------------------------------------------------------------------
  // Field map
  // ----------------------------------------------------------------------------
  function automatic logic [14:0] fieldDesc(input int i);
    case (i)
      0:  fieldDesc = {`PST_LOC_TX_BYTES, `PST_FK_D};       // [R10]
      1:  fieldDesc = {`PST_LOC_TX_UNI, `PST_FK_L};         // [R7] [R10]
      2:  fieldDesc = {`PST_LOC_TX_UNI, `PST_FK_U};         // [R7] [R10]
      3:  fieldDesc = {`PST_LOC_TX_FC, `PST_FK_LL};         // [R8] [R10]
      4:  fieldDesc = {`PST_LOC_TX_FC, `PST_FK_UU};         // [R8] [R10]
      5:  fieldDesc = {`PST_LOC_RX_BYTES, `PST_FK_D};       // [R11]
      6:  fieldDesc = {`PST_LOC_RX_FRAMES, `PST_FK_D};      // [R11]
      7:  fieldDesc = {`PST_LOC_RX_TOTBYTES, `PST_FK_D};    // [R11]
      8:  fieldDesc = {`PST_LOC_RX_TOTFRM, `PST_FK_L};      // [R12]
      9:  fieldDesc = {`PST_LOC_RX_TOTFRM, `PST_FK_U};      // [R12]
      10: fieldDesc = {`PST_LOC_RX_MCBC, `PST_FK_LL};       // [R12]
      11: fieldDesc = {`PST_LOC_RX_MCBC, `PST_FK_UU};       // [R12]
      12: fieldDesc = {`PST_LOC_BIN64, `PST_FK_L};          // [R13]
      13: fieldDesc = {`PST_LOC_BIN64, `PST_FK_U};          // [R13]
      14: fieldDesc = {`PST_LOC_BIN65, `PST_FK_L};          // [R14]
      15: fieldDesc = {`PST_LOC_BIN65, `PST_FK_U};          // [R14]
      16: fieldDesc = {`PST_LOC_BIN128, `PST_FK_LL};        // [R15]
      17: fieldDesc = {`PST_LOC_BIN128, `PST_FK_UU};        // [R15]
      18: fieldDesc = {`PST_LOC_BIN512, `PST_FK_LL};        // [R15]
      19: fieldDesc = {`PST_LOC_BIN512, `PST_FK_UU};        // [R15]
      20: fieldDesc = {`PST_LOC_ERR_C, `PST_FK_LL};         // [R9] [R16]
      21: fieldDesc = {`PST_LOC_ERR_C, `PST_FK_U1};         // [R9] [R16]
      22: fieldDesc = {`PST_LOC_ERR_C, `PST_FK_U};          // [R9] [R16]
      23: fieldDesc = {`PST_LOC_ERR_D, `PST_FK_LL};         // [R16]
      24: fieldDesc = {`PST_LOC_ERR_D, `PST_FK_UU};         // [R16]
      25: fieldDesc = {`PST_LOC_COLL, `PST_FK_LL};          // [R16]
      26: fieldDesc = {`PST_LOC_COLL, `PST_FK_UU};          // [R16]
      27: fieldDesc = {`PST_LOC_DISC, `PST_FK_LL};          // [R16]
      28: fieldDesc = {`PST_LOC_DISC, `PST_FK_U1};          // [R16]
      29: fieldDesc = {`PST_LOC_DISC, `PST_FK_U};           // [R16]
      default: fieldDesc = {`PST_LOC_TX_BYTES, `PST_FK_D};
    endcase
  endfunction : fieldDesc

  function automatic logic [31:0] maskOf(input logic [5:0] w);
    maskOf = (w == `PST_W_D) ? 32'hFFFF_FFFF : ((32'h1 << w) - 32'h1);
  endfunction : maskOf

  // ----------------------------------------------------------------------------
  // Increment sources
  // ----------------------------------------------------------------------------
  wire logic inBin64   = frameLen == `PST_LEN_64;
  wire logic inBin65   = frameLen > `PST_LEN_64 && frameLen <= `PST_LEN_127;
  wire logic inBin128  = frameLen > `PST_LEN_127 && frameLen <= `PST_LEN_255;
  wire logic inBin256  = frameLen > `PST_LEN_255 && frameLen <= `PST_LEN_511;
  wire logic inBin512  = frameLen > `PST_LEN_511 && frameLen <= `PST_LEN_1023;
  wire logic inBin1024 = frameLen > `PST_LEN_1023 && frameLen <= `PST_LEN_1528;

  always_comb begin
    inc = macEvent;                                                      // [R4]
    inc[`PST_F_SEND_FAIL] = sendFailUnderrun | sendFailLateCol | sendFailSixteenCol; // [R17]
    // Bins see every completed frame of 64 to 1528 bytes, good or errored
    inc[`PST_F_BIN64]   = frameDone & inBin64;                           // [R18]
    inc[`PST_F_BIN65]   = frameDone & inBin65;                           // [R18]
    inc[`PST_F_BIN128]  = frameDone & inBin128;                          // [R18]
    inc[`PST_F_BIN256]  = frameDone & inBin256;                          // [R18]
    inc[`PST_F_BIN512]  = frameDone & inBin512;                          // [R18]
    inc[`PST_F_BIN1024] = frameDone & inBin1024;                         // [R18]
    inc[`PST_F_FILTER]  = filterDiscard;                                 // [R4]
    inc[`PST_F_DELAY]   = delayDiscard;                                  // [R4]
  end

  always_comb begin
    for (int i = 0; i < `PST_NUM_FLAGS; i++) begin
      amount[i] = 33'h0_0000_0001;
    end
    amount[`PST_F_TX_BYTES]    = 33'(txByteCount);
    amount[`PST_F_RX_BYTES]    = 33'(rxByteCount);
    amount[`PST_F_RX_TOTBYTES] = 33'(rxTotByteCount);
  end

  // ----------------------------------------------------------------------------
  // Field-wise update
  // ----------------------------------------------------------------------------
  // Each field is masked out, summed alone and masked back, so fields that share a
  // word all advance in one cycle and a carry never reaches the neighbour.
  always_comb begin
    logic [3:0]  loc;
    logic [4:0]  lo;
    logic [31:0] msk;
    logic [32:0] sum;
    logic [14:0] desc;
    loc  = 4'h0;
    lo   = 5'h00;
    msk  = 32'h0;
    sum  = 33'h0;
    desc = 15'h0;
    wrap = 30'h0;
    for (int l = 0; l < `PST_NUM_LOCS; l++) begin
      next_mem[l] = mem[l];
    end
    for (int i = 0; i < `PST_NUM_FLAGS; i++) begin
      if (inc[i]) begin
        desc = fieldDesc(i);
        loc  = desc[14:11];
        lo   = desc[10:6];
        msk  = maskOf(desc[5:0]);
        sum  = {1'b0, (next_mem[loc] >> lo) & msk} + amount[i];          // [R20]
        wrap[i] = sum > {1'b0, msk};                                     // [R2]
        next_mem[loc] = (next_mem[loc] & ~(msk << lo)) | ((sum[31:0] & msk) << lo); // [R2] [R20]
      end
    end
  end

  always_ff @(posedge clock) begin
    for (int l = 0; l < `PST_NUM_LOCS; l++) begin
      mem[l] <= rst ? `PST_RESET_WORD : next_mem[l];                     // [R6]
    end
  end

  always_comb begin
    for (int l = 0; l < `PST_NUM_LOCS; l++) begin
      memFlat[l*32 +: 32] = mem[l];
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  AST_FAIL_WRAPS_TO_ZERO: assert property (@(posedge clock) disable iff (rst) // [R2]
    wrap[2] |=> mem[`PST_LOC_TX_UNI][31:24] == 8'h00)
    else $error("send fail counter did not wrap to zero");
  AST_NO_CARRY_INTO_UPPER: assert property (@(posedge clock) disable iff (rst) // [R20]
    (wrap[28] && !inc[29]) |=> $stable(mem[`PST_LOC_DISC][31:24]))
    else $error("carry leaked into neighbour field");
  AST_HALVES_TOGETHER: assert property (@(posedge clock) disable iff (rst) // [R8]
    (inc[3] && inc[4]) |=>
      mem[`PST_LOC_TX_FC][15:0] == 16'($past(mem[`PST_LOC_TX_FC][15:0]) + 16'h1) &&
      mem[`PST_LOC_TX_FC][31:16] == 16'($past(mem[`PST_LOC_TX_FC][31:16]) + 16'h1))
    else $error("paired halves not both advanced");
  AST_MIDDLE_FIELD: assert property (@(posedge clock) disable iff (rst) // [R9]
    (inc[28] && !inc[27] && !inc[29]) |=>
      mem[`PST_LOC_DISC][23:16] == 8'($past(mem[`PST_LOC_DISC][23:16]) + 8'h1) &&
      $stable(mem[`PST_LOC_DISC][15:0]) && $stable(mem[`PST_LOC_DISC][31:24]))
    else $error("middle field update wrong");
  AST_BIN64_COUNTS: assert property (@(posedge clock) disable iff (rst) // [R13]
    (frameDone && frameLen == `PST_LEN_64) |=>
      mem[`PST_LOC_BIN64][23:0] == 24'($past(mem[`PST_LOC_BIN64][23:0]) + 24'h1))
    else $error("64 byte bin not advanced");
  AST_SEND_FAIL_COUNTS: assert property (@(posedge clock) disable iff (rst) // [R17]
    (sendFailUnderrun || sendFailSixteenCol) |=>
      mem[`PST_LOC_TX_UNI][31:24] == 8'($past(mem[`PST_LOC_TX_UNI][31:24]) + 8'h1))
    else $error("send fail counter not advanced");

endmodule : pst_counter_bank

//--- pst_stats_top.sv
// Per-port statistics counter bank with host read port and wrap notification
// ----------------------------------------------------------------------------
// Overview of operation
// (R1) Every port has its own full counter set, readable by the host.
// (R2) Each counter wraps to zero past its maximum value.
// (R3) Any counter wrap raises the interrupt toward the host.
// (R4) MAC feeds increments; filtering and delay discards come from managers.
// (R5) Notification is 64 bits: flags in 29..0, other status above.
// (R6) Counters live in numbered words, full width or split fields.
// (R7) 24-bit low field in 23..0, paired 8-bit field in 31..24.
// (R8) 16-bit low field in 15..0, paired 16-bit field in 31..16.
// (R9) Three-field word: 15..0, middle 23..16, upper 31..24.
// (R10) Flags 0..4: tx bytes, unicast/send fail, flow control/non-unicast.
// (R11) Flags 5..7: rx bytes, rx frames, total rx bytes, full words.
// (R12) Flags 8..11: total frames/flow control rx, multicast/broadcast.
// (R13) Flags 12,13: 64-byte frames and jabbers at word 8.
// (R14) Flags 14,15: 65-127 byte frames and oversize at word 9.
// (R15) Flags 16..19: 16-bit length bins in words A and B.
// (R16) Flags 20..29: error, collision and discard counters, words C..F.
// (R17) Send fail counts underrun, late collision and sixteen collisions.
// (R18) Length bins count good and errored frames alike.
// (R19) Wrap flag sticks until its notification is delivered, then clears.
// (R20) Shared-word increments all apply; no carry crosses fields.
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`include "pst_params.svh"

module pst_stats_top
  import pst_pkg::*;
#(
  parameter int NUM_PORTS = `PST_NUM_PORTS,
  parameter int LEN_W     = `PST_LEN_W,
  parameter int PW        = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1
) (
  // Clock and reset
  input  wire logic                     clock,
  input  wire logic                     rst,
  // Port MAC event inputs, one slice per port
  input  wire logic [NUM_PORTS*30-1:0]  macEvent,
  input  wire logic [NUM_PORTS-1:0]     sendFailUnderrun,
  input  wire logic [NUM_PORTS-1:0]     sendFailLateCol,
  input  wire logic [NUM_PORTS-1:0]     sendFailSixteenCol,
  input  wire logic [NUM_PORTS-1:0]     frameDone,
  input  wire logic [NUM_PORTS*LEN_W-1:0] frameLen,
  input  wire logic [NUM_PORTS*LEN_W-1:0] txByteCount,
  input  wire logic [NUM_PORTS*LEN_W-1:0] rxByteCount,
  input  wire logic [NUM_PORTS*LEN_W-1:0] rxTotByteCount,
  // Queue manager and buffer manager events
  input  wire logic [NUM_PORTS-1:0]     filterDiscard,
  input  wire logic [NUM_PORTS-1:0]     delayDiscard,
  // Host read port
  input  wire logic                     readReq,
  input  wire logic [PW-1:0]            readPort,
  input  wire logic [3:0]               readAddr,
  output logic [31:0]                   readData,
  output logic                          readValid,
  // Wrap notification toward the host
  output logic                          wrapValid,
  output logic [63:0]                   wrapWord,
  input  wire logic                     wrapAck,
  output logic                          irq
);

  logic [NUM_PORTS*16*32-1:0] allWords;
  logic [29:0]                bankWrap [NUM_PORTS];
  logic [29:0]                pending  [NUM_PORTS];
  logic [29:0]                next_pending [NUM_PORTS];
  logic [PW-1:0]              notePort;
  pst_note_state_t            noteState;

  // ----------------------------------------------------------------------------
  // Counter banks
  // ----------------------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : gBank
    pst_counter_bank #(
      .LEN_W (LEN_W)
    ) uBank (                                                    
      .clock              (clock),
      .rst                (rst),
      .macEvent           (macEvent[p*30 +: 30]),
      .sendFailUnderrun   (sendFailUnderrun[p]),
      .sendFailLateCol    (sendFailLateCol[p]),
      .sendFailSixteenCol (sendFailSixteenCol[p]),
      .frameDone          (frameDone[p]),
      .frameLen           (frameLen[p*LEN_W +: LEN_W]),
      .txByteCount        (txByteCount[p*LEN_W +: LEN_W]),
      .rxByteCount        (rxByteCount[p*LEN_W +: LEN_W]),
      .rxTotByteCount     (rxTotByteCount[p*LEN_W +: LEN_W]),
      .filterDiscard      (filterDiscard[p]),
      .delayDiscard       (delayDiscard[p]),
      .memFlat            (allWords[p*512 +: 512]),
      .wrap               (bankWrap[p])
    );
  end

  // ----------------------------------------------------------------------------
  // Host read path
  // ----------------------------------------------------------------------------
  // A port number beyond the bank reads as zero rather than aliasing
  wire logic        readInRange = int'(readPort) < NUM_PORTS;
  wire logic [31:0] readSel     = readInRange ?
                                  allWords[(int'(readPort) * 16 + int'(readAddr)) * 32 +: 32] :
                                  32'h0000_0000;

  always_ff @(posedge clock) begin
    readValid <= !rst && readReq;                                        // [R1]
    readData  <= rst ? 32'h0000_0000 : (readReq ? readSel : readData);   // [R1]
  end

  // ----------------------------------------------------------------------------
  // Sticky wrap flags and notification
  // ----------------------------------------------------------------------------
  logic [PW-1:0] firstPort;
  logic          anyPending;
  logic          anyNext;

  always_comb begin
    firstPort  = '0;
    anyPending = 1'b0;
    for (int p = NUM_PORTS - 1; p >= 0; p--) begin
      if (|pending[p]) begin
        firstPort  = PW'(p);
        anyPending = 1'b1;
      end
    end
  end

  wire logic ackTaken = (noteState == PST_NOTE_OFFER) && wrapAck;

  // A wrap landing in the clearing cycle is kept: set is applied after clear
  always_comb begin
    anyNext = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      next_pending[p] = pending[p];
      if (ackTaken && notePort == PW'(p)) begin
        next_pending[p] = pending[p] & ~wrapWord[29:0];                  // [R19]
      end
      next_pending[p] = next_pending[p] | bankWrap[p];                   // [R19]
      anyNext = anyNext | (|next_pending[p]);
    end
  end

  logic [63:0] noteCandidate;
  always_comb begin
    noteCandidate = 64'h0;
    noteCandidate[29:0] = pending[firstPort];                            // [R5]
    noteCandidate[`PST_NOTE_PORT_LO +: PW] = firstPort;                  // [R5]
  end

  always_ff @(posedge clock) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      pending[p] <= rst ? 30'h0 : next_pending[p];
    end
  end

  always_ff @(posedge clock) begin
    irq <= !rst && anyNext;                                              // [R3]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      noteState <= PST_NOTE_IDLE;
      wrapValid <= 1'b0;
      wrapWord  <= 64'h0;
      notePort  <= '0;
    end else begin
      unique case (noteState)
        PST_NOTE_IDLE: begin
          if (anyPending) begin
            noteState <= PST_NOTE_OFFER;
            wrapValid <= 1'b1;
            wrapWord  <= noteCandidate;                                  // [R5]
            notePort  <= firstPort;
          end
        end
        PST_NOTE_OFFER: begin
          if (wrapAck) begin
            noteState <= PST_NOTE_IDLE;
            wrapValid <= 1'b0;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  logic anyWrap;
  always_comb begin
    anyWrap = 1'b0;
    for (int p = 0; p < NUM_PORTS; p++) begin
      anyWrap = anyWrap | (|bankWrap[p]);
    end
  end

  sequence noteOffered;
    wrapValid && !wrapAck;
  endsequence

  sequence noteHeld;
    wrapValid && $stable(wrapWord);
  endsequence

  AST_READ_ONE_CYCLE: assert property (@(posedge clock) disable iff (rst) // [R1]
    readValid == $past(readReq))
    else $error("read answer not one cycle after request");
  AST_WRAP_RAISES_IRQ: assert property (@(posedge clock) disable iff (rst) // [R3]
    anyWrap |=> irq)
    else $error("wrap did not raise interrupt");
  AST_FLAG_STICKS: assert property (@(posedge clock) disable iff (rst) // [R19]
    bankWrap[1][2] |=> pending[1][2])
    else $error("wrap flag not captured");
  AST_NOTE_HOLDS: assert property (@(posedge clock) disable iff (rst) // [R19]
    noteOffered |=> noteHeld)
    else $error("notification dropped before acknowledge");
  AST_NOTE_CLEARS: assert property (@(posedge clock) disable iff (rst) // [R19]
    (wrapValid && wrapAck && notePort == PW'(1) && bankWrap[1] == 30'h0) |=>
      (pending[1] & $past(wrapWord[29:0])) == 30'h0)
    else $error("delivered flags not cleared");
  AST_NOTE_HAS_FLAGS: assert property (@(posedge clock) disable iff (rst) // [R5]
    $rose(wrapValid) |-> wrapWord[29:0] != 30'h0 && wrapWord[63:`PST_NOTE_PORT_LO+PW] == '0)
    else $error("notification word malformed");

endmodule : pst_stats_top

//--- pst_host_model.sv
// Host-side model that accepts wrap notifications after a set delay
`timescale 1ns/1ps

module pst_host_model #(
  parameter int DLY = 3
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // Notification handshake
  input  wire logic wrapValid,
  output logic      wrapAck
);
  int cnt;

  // Ack is held until the edge that samples it, then dropped at once
  always_ff @(posedge clock) begin
    if (rst || !wrapValid || wrapAck) begin
      cnt     <= 0;
      wrapAck <= 1'b0;
    end else if (cnt == DLY) begin
      wrapAck <= 1'b1;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : pst_host_model

//--- tb_pst_stats_top.sv
// Self-checking bench of the port statistics counter bank
`timescale 1ns/1ps

module tb_pst_stats_top;
  import pst_pkg::*;
  logic clock = 0, rst = 1, readReq = 0, wrapAck;
  logic [299:0] macEvent = '0;
  logic [9:0] sendFailUnderrun = '0, sendFailLateCol = '0, sendFailSixteenCol = '0;
  logic [9:0] frameDone = '0, filterDiscard = '0, delayDiscard = '0;
  logic [159:0] frameLen = '0, txByteCount = '0, rxByteCount = '0, rxTotByteCount = '0;
  logic [3:0] readPort = '0, readAddr = '0;
  logic [31:0] readData;
  logic [63:0] wrapWord;
  logic readValid, wrapValid, irq;
  int miscompares = 0, checks_done = 0, cyc = 0;

  pst_stats_top pst_stats_top_inst (.clock, .rst, .macEvent, .sendFailUnderrun,
    .sendFailLateCol, .sendFailSixteenCol, .frameDone, .frameLen, .txByteCount,
    .rxByteCount, .rxTotByteCount, .filterDiscard, .delayDiscard, .readReq, .readPort,
    .readAddr, .readData, .readValid, .wrapValid, .wrapWord, .wrapAck, .irq);
  pst_host_model pst_host_model_inst (.clock, .rst, .wrapValid, .wrapAck);

  always #5 clock = ~clock;
  // Whole run needs under 1000 cycles; the ceiling leaves ample margin
  always @(posedge clock) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [64:0] g, input logic [64:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic zero();
    @(posedge clock) begin
      macEvent <= '0; sendFailUnderrun <= '0; sendFailLateCol <= '0; sendFailSixteenCol <= '0;
      frameDone <= '0; filterDiscard <= '0; delayDiscard <= '0; rxTotByteCount <= '0;
      txByteCount <= '0; rxByteCount <= '0;
    end
  endtask : zero
  task automatic rd(input int p, input logic [3:0] a, input logic [31:0] e);
    @(posedge clock) begin readReq <= 1'b1; readPort <= 4'(p); readAddr <= a; end
    @(posedge clock) readReq <= 1'b0;
    #1 chk({readValid, readData}, {1'b1, e});
  endtask : rd
  task automatic fr(input logic [15:0] len);
    @(posedge clock) begin frameDone[0] <= 1'b1; frameLen[15:0] <= len; end
    zero();
  endtask : fr
  task automatic wt(input int p, input logic [29:0] f);
    for (int i = 0; i < 20 && wrapValid !== 1'b1; i++) @(posedge clock) #1;
    chk({irq, wrapWord}, {1'b1, 30'h0, 4'(p), f});
    for (int i = 0; i < 20 && wrapValid === 1'b1; i++) @(posedge clock) #1;
  endtask : wt
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    rd(0, 4'h0, 32'h0);
    // Every field of shared words 1, 2, C and F of port 3 hit in one cycle
    @(posedge clock) begin
      macEvent[90+:30] <= 30'h2070001A; sendFailLateCol[3] <= 1'b1;
      filterDiscard[3] <= 1'b1; delayDiscard[3] <= 1'b1; rxTotByteCount[15:0] <= 16'h1234;
      macEvent[0+:8] <= 8'hA1; txByteCount[15:0] <= 16'h0040;
      rxByteCount[15:0] <= 16'h05F8;
    end
    zero();
    rd(3, 4'h1, 32'h01000001);
    rd(3, 4'h2, 32'h00010001);
    rd(3, 4'hC, 32'h01010001);
    rd(3, 4'hF, 32'h01010001);
    rd(0, 4'h5, 32'h00001234);
    rd(0, 4'h0, 32'h00000040);
    rd(0, 4'h3, 32'h000005F8);
    $display("layout test done");
    fr(16'h0040); fr(16'h05F8); fr(16'h05F9); fr(16'h0064);
    rd(0, 4'h8, 32'h00000001);
    rd(0, 4'h9, 32'h00000001);
    rd(0, 4'hB, 32'h00010000);
    $display("bin test done");
    // Send-fail sources rotate; both ports wrap on the same edge
    for (int i = 0; i < 256; i++) begin
      @(posedge clock) begin
        if (i % 3 == 0) sendFailUnderrun <= {6'h0, i > 0, 3'h2};
        if (i % 3 == 1) sendFailSixteenCol <= 10'h00A;
        if (i % 3 == 2) sendFailLateCol <= 10'h00A;
        delayDiscard[1] <= 1'b1;
      end
      zero();
    end
    wt(1, 30'h10000004);
    wt(3, 30'h00000004);
    #1 chk(irq, 1'b0);
    rd(3, 4'h1, 32'h00000001);
    rd(10, 4'h1, 32'h0);
    rd(1, 4'hF, 32'h0);
    $display("wrap test done");
    tally_and_finish();
  end
endmodule : tb_pst_stats_top
